// ==== dv/ppp_prog_model.sv ====
// Programmer model that drives the parallel programming pins
`timescale 1ns/1ps
module ppp_prog_model (
	// Clock
	input wire logic ref_clk_i,
	// Device side of the data bus
	input wire logic [7:0] dev_data_i,
	input wire logic dev_oe_i,
	// Programmer pins
	output logic load_clock_o,
	output logic [1:0] action_o,
	output logic [1:0] byte_sel_o,
	output logic page_latch_o,
	output logic write_n_o,
	output logic output_enable_n_o,
	output logic [7:0] bus_o
);
	logic [7:0] drv_reg;
	logic released;

	// Bus level; a released bus shows the inverse so a stale value never passes
	assign bus_o = dev_oe_i ? dev_data_i : (released ? ~drv_reg : drv_reg);

	// Idle pin levels from time zero
	initial
	begin
		load_clock_o = 1'b0;
		action_o = 2'h3;
		byte_sel_o = 2'h0;
		page_latch_o = 1'b0;
		write_n_o = 1'b1;
		output_enable_n_o = 1'b1;
		drv_reg = 8'h00;
		released = 1'b1;
	end

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	// one load clock frame, 160 ns high and low
	task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
		action_o = act;
		byte_sel_o = bs;
		drv_reg = d;
		released = 1'b0;
		step(4);
		load_clock_o = 1'b1;
		step(4);
		load_clock_o = 1'b0;
		step(4);
		action_o = 2'h3;
		released = 1'b1;
		// Idle gap so a following frame never reassigns a pin in this step
		step(1);
	endtask

	// page latch pulse with the low select held
	task automatic latch(input logic bs_lo);
		byte_sel_o[0] = bs_lo;
		step(4);
		page_latch_o = 1'b1;
		step(4);
		page_latch_o = 1'b0;
		step(4);
	endtask

	// write pulse, selects restored to 00 after it
	task automatic wr(input logic [1:0] bs);
		byte_sel_o = bs;
		step(4);
		write_n_o = 1'b0;
		step(4);
		write_n_o = 1'b1;
		step(4);
		byte_sel_o = 2'h0;
		// Idle gap so back-to-back pulses never reassign the selects at once
		step(1);
	endtask

	// Read cycle: the bus is released while output enable is low
	task automatic rd(input logic [1:0] bs, output logic [7:0] v, output logic oe);
		byte_sel_o = bs;
		released = 1'b1;
		output_enable_n_o = 1'b0;
		step(8);
		v = dev_data_i;
		oe = dev_oe_i;
		output_enable_n_o = 1'b1;
		step(4);
	endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the parallel programming port
`timescale 1ns/1ps
module tb_top;
	localparam int PROG = 200;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic lck, pgl, wrn, oen, oe, rdy, ov;
	logic [1:0] act, bs;
	logic [7:0] bus, dout, fl, fh, fe, lb, v, d, lk;
	logic [7:0] fd [3];
	logic [15:0] exp_fl [8];
	logic [7:0] exp_ee [8];
	logic [4:0] pg;
	logic [2:0] skip;
	int err_total, checked, busy_len, seed;

	// 25 MHz reference clock
	always #20 ref_clk_i = ~ref_clk_i;

	ppp_port #(.FLASH_AW(8), .FLASH_PW(3), .EE_AW(6), .PROG_CYCLES(PROG)) dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .load_clock_in_i(lck),
		.action_select_hi_i(act[1]), .action_select_lo_i(act[0]),
		.byte_select_hi_i(bs[1]), .byte_select_lo_i(bs[0]),
		.page_latch_strobe_i(pgl), .write_n_i(wrn), .output_enable_n_i(oen),
		.data_i(bus), .data_o(dout), .data_oe_o(oe), .ready_flag_o(rdy),
		.fuse_low_o(fl), .fuse_high_o(fh), .fuse_ext_o(fe), .lock_byte_o(lb));

	ppp_prog_model prog (
		.ref_clk_i(ref_clk_i), .dev_data_i(dout), .dev_oe_i(oe), .load_clock_o(lck),
		.action_o(act), .byte_sel_o(bs), .page_latch_o(pgl), .write_n_o(wrn),
		.output_enable_n_o(oen), .bus_o(bus));

	task automatic finish_test;
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Lock bits only clear to 0; boot bits frozen once both mode bits are programmed
	function automatic logic [7:0] lock_next(input logic [7:0] old, input logic [7:0] dat);
		logic [7:0] r;
		r = old & dat;
		if (old[1:0] == 2'b00)
			r[5:2] = old[5:2];
		return r;
	endfunction

	task automatic cmd(input logic [7:0] c);
		prog.load(2'h2, 2'h0, c);
	endtask

	task automatic wait_ready;
		int n;
		for (n = 0; n < PROG + 100 && rdy !== 1'b1; n++)
			@(negedge ref_clk_i);
		chk("ready timeout", 16'h1, {15'h0, rdy});
		if (rdy !== 1'b1)
			finish_test();
	endtask

	task automatic do_wr(input logic [1:0] sel, input logic acc);
		prog.wr(sel);
		chk("ready after write", {15'h0, !acc}, {15'h0, rdy});
		if (acc)
			wait_ready();
	endtask

	task automatic rd_chk(input string what, input logic [1:0] sel, input logic [7:0] exp);
		prog.rd(sel, v, ov);
		chk(what, {8'h0, exp}, {8'h0, v});
		chk("bus driven", 16'h1, {15'h0, ov});
		chk("bus released", 16'h0, {15'h0, oe});
	endtask

	// Busy must stand for exactly the programming time
	always @(posedge ref_clk_i)
	begin
		if (rdy === 1'b0)
			busy_len <= busy_len + 1;
		else if (busy_len != 0)
		begin
			chk("busy length", 16'(PROG), 16'(busy_len));
			busy_len <= 0;
		end
	end

	initial
	begin
		seed = 32'hbccb;
		err_total = 0;
		checked = 0;
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_i = 1'b0;
		prog.step(4);
		chk("reset ready", 16'h1, {15'h0, rdy});
		chk("reset fuses", 16'hffff, {fl, fh});
		chk("reset ext lock", 16'hffff, {fe, lb});
		chk("reset oe", 16'h0, {15'h0, oe});
		// Flash page fill with one word left unlatched; page comes from the low byte
		pg = 5'($random(seed));
		skip = 3'($random(seed));
		cmd(8'h10);
		for (int w = 0; w < 8; w++)
		begin
			exp_fl[w] = 16'hffff;
			if (w != skip)
			begin
				exp_fl[w] = 16'($random(seed));
				prog.load(2'h0, 2'h0, {pg, 3'(w)});
				prog.load(2'h1, 2'h0, exp_fl[w][7:0]);
				prog.load(2'h1, 2'h1, exp_fl[w][15:8]);
				prog.latch(1'b1);
			end
		end
		prog.load(2'h0, 2'h1, 8'($random(seed)));
		prog.load(2'h0, 2'h2, 8'($random(seed)));
		do_wr(2'h0, 1'b1);
		cmd(8'h02);
		for (int w = 0; w < 8; w++)
		begin
			prog.load(2'h0, 2'h2, 8'($random(seed)));
			prog.load(2'h0, 2'h0, {pg, 3'(w)});
			rd_chk("flash low", 2'h0, exp_fl[w][7:0]);
			rd_chk("flash high", 2'h1, exp_fl[w][15:8]);
		end
		// EEPROM page, both latch select levels
		cmd(8'h11);
		prog.load(2'h0, 2'h1, 8'h00);
		for (int b = 0; b < 8; b++)
		begin
			exp_ee[b] = 8'hff;
			if (b != skip)
			begin
				exp_ee[b] = 8'($random(seed));
				prog.load(2'h0, 2'h0, {2'b00, pg[2:0], 3'(b)});
				prog.load(2'h1, 2'h0, exp_ee[b]);
				prog.latch(b[0]);
			end
		end
		do_wr(2'h0, 1'b1);
		cmd(8'h03);
		for (int b = 0; b < 8; b++)
		begin
			prog.load(2'h0, 2'h0, {2'b00, pg[2:0], 3'(b)});
			rd_chk("eeprom byte", 2'h0, exp_ee[b]);
		end
		// Writes refused: after no-op, reserved selects, flash read command
		cmd(8'h00);
		do_wr(2'h0, 1'b0);
		cmd(8'h10);
		do_wr(2'h3, 1'b0);
		cmd(8'h02);
		do_wr(2'h0, 1'b0);
		cmd(8'h40);
		do_wr(2'h3, 1'b0);
		// Fuse bytes, with a stray write while busy
		for (int i = 0; i < 3; i++)
		begin
			fd[i] = 8'($random(seed));
			prog.load(2'h1, 2'h0, fd[i]);
			prog.wr(2'(i));
			chk("fuse busy", 16'h0, {15'h0, rdy});
			prog.wr(2'((i + 1) % 3));
			wait_ready();
		end
		chk("fuse low high", {fd[0], fd[1]}, {fl, fh});
		chk("fuse ext", {8'h0, fd[2]}, {8'h0, fe});
		// Lock bits: boot bits frozen in mode 3, never return to 1
		lk = 8'hff;
		cmd(8'h20);
		for (int i = 0; i < 4; i++)
		begin
			d = (i == 0) ? 8'hfb : (i == 1) ? 8'hfc : (i == 2) ? 8'he3 : 8'hff;
			prog.load(2'h1, 2'h0, d);
			do_wr(2'h0, 1'b1);
			lk = lock_next(lk, d);
			chk("lock byte", {8'h0, lk}, {8'h0, lb});
		end
		cmd(8'h04);
		rd_chk("read fuse low", 2'h0, fd[0]);
		rd_chk("read fuse high", 2'h3, fd[1]);
		rd_chk("read fuse ext", 2'h2, fd[2]);
		rd_chk("read lock", 2'h1, lk);
		finish_test();
	end
endmodule

// ==== pkg/ppp_consts.svh ====
// Constants for the parallel memory programming port
// Summary of operation
// - Action 10, low select 0: load command
// - Command 0x10 enables flash page loading, writing
// - Action 00, selects 00: address bits 7:0
// - Action 01, low select 0: data low byte
// - Action 01, low select 1: data high byte
// - Page latch with select 1 fills buffer word
// - Low address bits pick word, upper bits page
// - Action 00, selects 01: address bits 15:8
// - Action 00, selects 10: address bits 23:16
// - Write strobe low, selects 00: program page, busy
// - Command 0x00 is no-operation, ends write session
// - Command 0x11 programs buffered EEPROM page likewise
// - Command 0x02: read flash low/high byte
// - Command 0x03: read addressed EEPROM byte
// - Command 0x40: fuse bit 0 programs, 1 erases
// - Selects 00/01/10 pick low/high/extended fuse byte
// - Command 0x20: zero bits program lock bits
// - Lock mode 3 blocks boot lock programming
// - Lock bits never return unprogrammed here
// - Command 0x04 reads fuses and lock byte
// - Ready flag low while programming runs
// - Command and address kept across operations
// - Data bus driven only while output enable low
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH

// Action selector codes
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2

// Byte selector codes {hi, lo}
`define PPP_BS_LOW 2'h0
`define PPP_BS_HIGH 2'h1
`define PPP_BS_EXT 2'h2
`define PPP_BS_RSVD 2'h3

// Command bytes
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EE 8'h11
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EE 8'h03

// Lock byte fields
`define PPP_LOCK_MODE_MSB 1
`define PPP_LOCK_MODE_LSB 0
`define PPP_LOCK_BOOT_MSB 5
`define PPP_LOCK_BOOT_LSB 2

// Reset values
`define PPP_FUSE_RST 8'hff
`define PPP_LOCK_RST 8'hff
`define PPP_ERASED_BYTE 8'hff
`define PPP_ERASED_WORD 16'hffff
`define PPP_PINS_RST 16'h0300

// Programming time and clock period, in ns
`define PPP_T_PROG_NS 3700000
`define PPP_CLK_NS 40
`define PPP_PROG_CYC ((`PPP_T_PROG_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)

`endif

// ==== pkg/ppp_mem_if.sv ====
// Write and read ports between the port controller and the arrays
`timescale 1ns/1ps
interface ppp_mem_if #(
	parameter int FLASH_AW = 17,
	parameter int EE_AW = 12
);
	logic flash_we;
	logic [FLASH_AW-1:0] flash_waddr;
	logic [15:0] flash_wdata;
	logic [FLASH_AW-1:0] flash_raddr;
	logic [15:0] flash_rdata;
	logic ee_we;
	logic [EE_AW-1:0] ee_waddr;
	logic [7:0] ee_wdata;
	logic [EE_AW-1:0] ee_raddr;
	logic [7:0] ee_rdata;

	modport ctrl (
		output flash_we, flash_waddr, flash_wdata, flash_raddr,
		output ee_we, ee_waddr, ee_wdata, ee_raddr,
		input flash_rdata, ee_rdata
	);

	modport mem (
		input flash_we, flash_waddr, flash_wdata, flash_raddr,
		input ee_we, ee_waddr, ee_wdata, ee_raddr,
		output flash_rdata, ee_rdata
	);
endinterface

// ==== pkg/ppp_pkg.sv ====
// Types shared by the programming port modules
package ppp_pkg;

	// Sampled pin bundle, one bit each unless noted
	typedef struct packed {
		logic load_clock_in;
		logic [1:0] action_select;
		logic [1:0] byte_select;
		logic page_latch_strobe;
		logic write_n;
		logic output_enable_n;
		logic [7:0] data;
	} ppp_pins_s;

	typedef enum logic {
		PPP_IDLE,
		PPP_BUSY
	} ppp_state_e;

endpackage

// ==== rtl/ppp_nvm.sv ====
// Flash and EEPROM arrays held in flip-flops
`timescale 1ns/1ps
module ppp_nvm #(
	parameter int FLASH_AW = 17,
	parameter int EE_AW = 12
) (
	// Clock
	input wire logic ref_clk_i,
	// Array ports
	ppp_mem_if.mem mem
);
	logic [15:0] flash_mem [2**FLASH_AW];
	logic [7:0] ee_mem [2**EE_AW];

	// Array contents carry no reset, like real non-volatile cells
	always_ff @(posedge ref_clk_i)
	begin
		if (mem.flash_we)
		begin
			flash_mem[mem.flash_waddr] <= mem.flash_wdata;
		end
		if (mem.ee_we)
		begin
			ee_mem[mem.ee_waddr] <= mem.ee_wdata;
		end
	end

	// Asynchronous read; the controller registers the result
	assign mem.flash_rdata = flash_mem[mem.flash_raddr];
	assign mem.ee_rdata = ee_mem[mem.ee_raddr];
endmodule

// ==== rtl/ppp_port.sv ====
// Parallel programming port controller with fuses and lock bits
`timescale 1ns/1ps
`include "ppp_consts.svh"
module ppp_port #(
	parameter int FLASH_AW = 17,
	parameter int FLASH_PW = 7,
	parameter int EE_AW = 12,
	parameter int EE_PW = 3,
	parameter int PROG_CYCLES = `PPP_PROG_CYC,
	parameter logic [7:0] FUSE_LO_RST = `PPP_FUSE_RST,
	parameter logic [7:0] FUSE_HI_RST = `PPP_FUSE_RST,
	parameter logic [7:0] FUSE_EXT_RST = `PPP_FUSE_RST
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Programmer strobes and selectors
	input wire logic load_clock_in_i,
	input wire logic action_select_hi_i,
	input wire logic action_select_lo_i,
	input wire logic byte_select_hi_i,
	input wire logic byte_select_lo_i,
	input wire logic page_latch_strobe_i,
	input wire logic write_n_i,
	input wire logic output_enable_n_i,
	// Bidirectional data bus
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	// Status
	output logic ready_flag_o,
	output logic [7:0] fuse_low_o,
	output logic [7:0] fuse_high_o,
	output logic [7:0] fuse_ext_o,
	output logic [7:0] lock_byte_o
);
	localparam int FPAGE = 2**FLASH_PW;
	localparam int EPAGE = 2**EE_PW;
	localparam int CW = $clog2(PROG_CYCLES + 1);

	ppp_mem_if #(.FLASH_AW(FLASH_AW), .EE_AW(EE_AW)) mif ();

	ppp_nvm #(.FLASH_AW(FLASH_AW), .EE_AW(EE_AW)) u_nvm (
		.ref_clk_i(ref_clk_i),
		.mem(mif.mem)
	);

	ppp_pkg::ppp_pins_s pins_raw;
	ppp_pkg::ppp_pins_s sync1_reg;
	ppp_pkg::ppp_pins_s sync2_reg;
	ppp_pkg::ppp_pins_s prev_reg;
	ppp_pkg::ppp_state_e state_reg, state_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [7:0] op_reg, op_next;
	logic [23:0] addr_reg, addr_next;
	logic [7:0] dlo_reg, dlo_next;
	logic [7:0] dhi_reg, dhi_next;
	logic [FLASH_AW-FLASH_PW-1:0] fpage_reg, fpage_next;
	logic [EE_AW-EE_PW-1:0] epage_reg, epage_next;
	logic [15:0] fbuf_reg [FPAGE];
	logic [15:0] fbuf_next [FPAGE];
	logic [7:0] ebuf_reg [EPAGE];
	logic [7:0] ebuf_next [EPAGE];
	logic [7:0] fuse_lo_reg, fuse_lo_next;
	logic [7:0] fuse_hi_reg, fuse_hi_next;
	logic [7:0] fuse_ext_reg, fuse_ext_next;
	logic [7:0] lock_reg, lock_next;
	logic [7:0] dout_reg, dout_next;
	logic load_evt;
	logic latch_evt;
	logic wr_evt;
	logic wr_ok;
	logic flash_walk;
	logic ee_walk;

	assign pins_raw = '{load_clock_in: load_clock_in_i,
		action_select: {action_select_hi_i, action_select_lo_i},
		byte_select: {byte_select_hi_i, byte_select_lo_i},
		page_latch_strobe: page_latch_strobe_i,
		write_n: write_n_i,
		output_enable_n: output_enable_n_i,
		data: data_i};

	// Two-stage synchroniser plus a third stage for edge finding
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= `PPP_PINS_RST;
			sync2_reg <= `PPP_PINS_RST;
			prev_reg <= `PPP_PINS_RST;
		end
		else
		begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign load_evt = sync2_reg.load_clock_in & ~prev_reg.load_clock_in;
	assign latch_evt = sync2_reg.page_latch_strobe & ~prev_reg.page_latch_strobe;
	assign wr_evt = ~sync2_reg.write_n & prev_reg.write_n;

	always_comb
	begin
		wr_ok = 1'b0;
		if (state_reg == ppp_pkg::PPP_IDLE && wr_evt)
		begin
			if (cmd_reg == `PPP_CMD_WR_FLASH || cmd_reg == `PPP_CMD_WR_EE)
			begin
				wr_ok = (sync2_reg.byte_select == `PPP_BS_LOW);
			end
			else if (cmd_reg == `PPP_CMD_WR_FUSE)
			begin
				wr_ok = (sync2_reg.byte_select != `PPP_BS_RSVD);
			end
			else if (cmd_reg == `PPP_CMD_WR_LOCK)
			begin
				wr_ok = 1'b1;
			end
		end
	end

	// Page walk: one buffered word or byte goes to the array per cycle over the first FPAGE or EPAGE busy cycles
	assign flash_walk = (state_reg == ppp_pkg::PPP_BUSY) && (op_reg == `PPP_CMD_WR_FLASH)
		&& (cnt_reg < CW'(FPAGE));
	assign ee_walk = (state_reg == ppp_pkg::PPP_BUSY) && (op_reg == `PPP_CMD_WR_EE)
		&& (cnt_reg < CW'(EPAGE));

	assign mif.flash_we = flash_walk;
	assign mif.flash_waddr = {fpage_reg, cnt_reg[FLASH_PW-1:0]};
	assign mif.flash_wdata = fbuf_reg[cnt_reg[FLASH_PW-1:0]];
	assign mif.ee_we = ee_walk;
	assign mif.ee_waddr = {epage_reg, cnt_reg[EE_PW-1:0]};
	assign mif.ee_wdata = ebuf_reg[cnt_reg[EE_PW-1:0]];
	assign mif.flash_raddr = addr_reg[FLASH_AW-1:0];
	assign mif.ee_raddr = addr_reg[EE_AW-1:0];

	// Load decode, page latching and the programming sequence
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cmd_next = cmd_reg;
		op_next = op_reg;
		addr_next = addr_reg;
		dlo_next = dlo_reg;
		dhi_next = dhi_reg;
		fpage_next = fpage_reg;
		epage_next = epage_reg;
		fbuf_next = fbuf_reg;
		ebuf_next = ebuf_reg;
		fuse_lo_next = fuse_lo_reg;
		fuse_hi_next = fuse_hi_reg;
		fuse_ext_next = fuse_ext_reg;
		lock_next = lock_reg;
		if (load_evt)
		begin
			if (sync2_reg.action_select == `PPP_ACT_CMD && !sync2_reg.byte_select[0])
			begin
				cmd_next = sync2_reg.data;
			end
			else if (sync2_reg.action_select == `PPP_ACT_ADDR)
			begin
				if (sync2_reg.byte_select == `PPP_BS_LOW)
				begin
					addr_next[7:0] = sync2_reg.data;
				end
				else if (sync2_reg.byte_select == `PPP_BS_HIGH)
				begin
					addr_next[15:8] = sync2_reg.data;
				end
				else if (sync2_reg.byte_select == `PPP_BS_EXT)
				begin
					addr_next[23:16] = sync2_reg.data;
				end
			end
			else if (sync2_reg.action_select == `PPP_ACT_DATA)
			begin
				if (!sync2_reg.byte_select[0])
				begin
					dlo_next = sync2_reg.data;
				end
				else
				begin
					dhi_next = sync2_reg.data;
				end
			end
		end
		if (latch_evt && sync2_reg.byte_select[0])
		begin
			if (cmd_reg == `PPP_CMD_WR_FLASH)
			begin
				fbuf_next[addr_reg[FLASH_PW-1:0]] = {dhi_reg, dlo_reg};
			end
			else if (cmd_reg == `PPP_CMD_WR_EE)
			begin
				ebuf_next[addr_reg[EE_PW-1:0]] = dlo_reg;
			end
		end
		if (latch_evt && !sync2_reg.byte_select[0] && cmd_reg == `PPP_CMD_WR_EE)
		begin
			ebuf_next[addr_reg[EE_PW-1:0]] = dlo_reg;
		end
		case (state_reg)
			ppp_pkg::PPP_IDLE:
			begin
				if (wr_ok)
				begin
					state_next = ppp_pkg::PPP_BUSY;
					cnt_next = '0;
					op_next = cmd_reg;
					fpage_next = addr_reg[FLASH_AW-1:FLASH_PW];
					epage_next = addr_reg[EE_AW-1:EE_PW];
					if (cmd_reg == `PPP_CMD_WR_FUSE)
					begin
						if (sync2_reg.byte_select == `PPP_BS_LOW)
						begin
							fuse_lo_next = dlo_reg;
						end
						else if (sync2_reg.byte_select == `PPP_BS_HIGH)
						begin
							fuse_hi_next = dlo_reg;
						end
						else
						begin
							fuse_ext_next = dlo_reg;
						end
					end
					else if (cmd_reg == `PPP_CMD_WR_LOCK)
					begin
						lock_next = lock_reg & dlo_reg;
						// boot bits frozen in mode 3
						if (lock_reg[`PPP_LOCK_MODE_MSB:`PPP_LOCK_MODE_LSB] == 2'h0)
						begin
							lock_next[`PPP_LOCK_BOOT_MSB:`PPP_LOCK_BOOT_LSB] =
								lock_reg[`PPP_LOCK_BOOT_MSB:`PPP_LOCK_BOOT_LSB];
						end
					end
				end
			end
			ppp_pkg::PPP_BUSY:
			begin
				// Written words return to erased so the next page starts clean
				if (flash_walk)
				begin
					fbuf_next[cnt_reg[FLASH_PW-1:0]] = `PPP_ERASED_WORD;
				end
				if (ee_walk)
				begin
					ebuf_next[cnt_reg[EE_PW-1:0]] = `PPP_ERASED_BYTE;
				end
				// busy for the full programming time
				if (cnt_reg == CW'(PROG_CYCLES - 1))
				begin
					state_next = ppp_pkg::PPP_IDLE;
				end
				else
				begin
					cnt_next = cnt_reg + CW'(1);
				end
			end
			default:
			begin
				state_next = ppp_pkg::PPP_IDLE;
			end
		endcase
	end

	// Read path multiplexer, registered toward the bus
	always_comb
	begin
		dout_next = dout_reg;
		if (cmd_reg == `PPP_CMD_RD_FLASH)
		begin
			dout_next = sync2_reg.byte_select[0] ? mif.flash_rdata[15:8] : mif.flash_rdata[7:0];
		end
		else if (cmd_reg == `PPP_CMD_RD_EE)
		begin
			dout_next = mif.ee_rdata;
		end
		else if (cmd_reg == `PPP_CMD_RD_FUSE)
		begin
			if (sync2_reg.byte_select == `PPP_BS_LOW)
			begin
				dout_next = fuse_lo_reg;
			end
			else if (sync2_reg.byte_select == `PPP_BS_RSVD)
			begin
				dout_next = fuse_hi_reg;
			end
			else if (sync2_reg.byte_select == `PPP_BS_EXT)
			begin
				dout_next = fuse_ext_reg;
			end
			else
			begin
				dout_next = lock_reg;
			end
		end
	end

	// State registers; the page buffers reset to erased
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= ppp_pkg::PPP_IDLE;
			cnt_reg <= '0;
			cmd_reg <= `PPP_CMD_NOP;
			op_reg <= `PPP_CMD_NOP;
			addr_reg <= '0;
			dlo_reg <= `PPP_ERASED_BYTE;
			dhi_reg <= `PPP_ERASED_BYTE;
			fpage_reg <= '0;
			epage_reg <= '0;
			fbuf_reg <= '{default: `PPP_ERASED_WORD};
			ebuf_reg <= '{default: `PPP_ERASED_BYTE};
			fuse_lo_reg <= FUSE_LO_RST;
			fuse_hi_reg <= FUSE_HI_RST;
			fuse_ext_reg <= FUSE_EXT_RST;
			lock_reg <= `PPP_LOCK_RST;
			dout_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cmd_reg <= cmd_next;
			op_reg <= op_next;
			addr_reg <= addr_next;
			dlo_reg <= dlo_next;
			dhi_reg <= dhi_next;
			fpage_reg <= fpage_next;
			epage_reg <= epage_next;
			fbuf_reg <= fbuf_next;
			ebuf_reg <= ebuf_next;
			fuse_lo_reg <= fuse_lo_next;
			fuse_hi_reg <= fuse_hi_next;
			fuse_ext_reg <= fuse_ext_next;
			lock_reg <= lock_next;
			dout_reg <= dout_next;
		end
	end

	assign ready_flag_o = (state_reg == ppp_pkg::PPP_IDLE);
	// drive only with output enable low
	assign data_oe_o = ~sync2_reg.output_enable_n;
	assign data_o = dout_reg;
	assign fuse_low_o = fuse_lo_reg;
	assign fuse_high_o = fuse_hi_reg;
	assign fuse_ext_o = fuse_ext_reg;
	assign lock_byte_o = lock_reg;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_flash_start;
		wr_evt && state_reg == ppp_pkg::PPP_IDLE && cmd_reg == `PPP_CMD_WR_FLASH
			&& sync2_reg.byte_select == `PPP_BS_LOW;
	endsequence

	sequence s_busy_run;
		!ready_flag_o [*8];
	endsequence

	AST_CMD_LOAD: assert property (load_evt && sync2_reg.action_select == `PPP_ACT_CMD
		&& !sync2_reg.byte_select[0] |=> cmd_reg == $past(sync2_reg.data))
		else $error("command byte not captured");
	AST_ADDR_LO: assert property (load_evt && sync2_reg.action_select == `PPP_ACT_ADDR
		&& sync2_reg.byte_select == `PPP_BS_LOW |=> addr_reg[7:0] == $past(sync2_reg.data))
		else $error("address low byte not captured");
	AST_ADDR_HI: assert property (load_evt && sync2_reg.action_select == `PPP_ACT_ADDR
		&& sync2_reg.byte_select == `PPP_BS_HIGH |=> addr_reg[15:8] == $past(sync2_reg.data))
		else $error("address high byte not captured");
	AST_DATA_HI: assert property (load_evt && sync2_reg.action_select == `PPP_ACT_DATA
		&& sync2_reg.byte_select[0] |=> dhi_reg == $past(sync2_reg.data) && $stable(dlo_reg))
		else $error("data high byte not captured");
	AST_FLASH_BUSY: assert property (s_flash_start |=> s_busy_run)
		else $error("ready flag did not fall for page write");
	AST_BUSY_END: assert property (state_reg == ppp_pkg::PPP_BUSY
		&& cnt_reg == CW'(PROG_CYCLES - 1) |=> ready_flag_o)
		else $error("ready flag did not return after programming");
	AST_LOCK_NO_CLEAR: assert property (##1 (lock_reg & ~$past(lock_reg)) == 8'h00)
		else $error("lock bit returned to unprogrammed");
	AST_BOOT_FROZEN: assert property (lock_reg[`PPP_LOCK_MODE_MSB:`PPP_LOCK_MODE_LSB] == 2'h0
		|=> $stable(lock_reg[`PPP_LOCK_BOOT_MSB:`PPP_LOCK_BOOT_LSB]))
		else $error("boot lock bits changed in lock mode 3");
	AST_BUSY_IGNORE: assert property (state_reg == ppp_pkg::PPP_BUSY && wr_evt
		|=> $stable(fuse_lo_reg) && $stable(lock_reg) && $stable(op_reg))
		else $error("write strobe acted while busy");
	AST_OE_DRIVE: assert property (data_oe_o == !sync2_reg.output_enable_n)
		else $error("data bus driven without output enable");
endmodule
